// File: mfr_regs.sv
// meter, snapshot, fault capture and auto restart register bank
`timescale 1ns/1ps
`default_nettype none
module mfr_regs #(
    parameter logic [31:0] P_BASE_CYC = 32'(mfr_pkg::RESTART_BASE_CYC)
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // host register port
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    // meter
    input  wire logic        i_tick_wrap,
    input  wire logic        i_meter_ovf,
    output logic             o_meter_reset,
    output logic             o_meter_halt,
    input  wire logic        i_nvm_factory_locked,
    // converter
    output logic      [3:0]  o_snap_sel,
    output logic             o_snap_halt,
    input  wire logic        i_conv_done,
    // alert sources and masks
    input  wire logic [7:0]  i_fault,
    input  wire logic [39:0] i_alarm,
    input  wire logic [1:0]  i_cfg3_mask,
    input  wire logic        i_gpio_setup_two_mask,
    output logic             o_alert,
    // fault capture
    input  wire logic        i_fault_event,
    input  wire logic [7:0]  i_sense_now,
    input  wire logic [7:0]  i_sense_min,
    input  wire logic [7:0]  i_sense_max,
    input  wire logic [7:0]  i_rail_now,
    input  wire logic [7:0]  i_rail_min,
    input  wire logic [7:0]  i_rail_max,
    output logic             o_nvm_we,
    output logic      [7:0]  o_nvm_addr,
    output logic      [7:0]  o_nvm_data,
    input  wire logic        i_nvm_ready,
    // auto restart
    input  wire logic        i_wp_pin,
    input  wire logic        i_cool_busy,
    output logic             o_restart
);
    // ==========================================================
    // types and helpers
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COPY = 3'b010,
        ST_FIN  = 3'b100
    } mfr_state_type;

    function automatic logic mask_hit(input logic [7:0] a);
        mask_hit = (a >= mfr_pkg::ADDR_MASK0) &&
                   (a < mfr_pkg::ADDR_MASK0 + mfr_pkg::MASK_CNT);
    endfunction

    function automatic logic [2:0] mask_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - mfr_pkg::ADDR_MASK0;
        mask_idx = d[2:0];
    endfunction

    // ==========================================================
    // state
    logic [7:0]    mask_r [6];
    logic [7:0]    mask_nxt [6];
    logic          mreset_r, mreset_nxt, mhalt_r, mhalt_nxt;
    logic          tick_r, tick_nxt, movf_r, movf_nxt;
    logic          alatch_r, alatch_nxt;
    logic [3:0]    sel_r, sel_nxt;
    logic          shalt_r, shalt_nxt;
    logic          len_r, len_nxt, unl_r, unl_nxt;
    logic          lst_r, lst_nxt, ldone_r, ldone_nxt;
    logic          lal_r, lal_nxt;
    mfr_state_type st_r, st_nxt;
    logic [3:0]    idx_r, idx_nxt;
    logic [7:0]    naddr_r, naddr_nxt, ndata_r, ndata_nxt;
    logic          ren_r, ren_nxt;
    logic [2:0]    rdl_r, rdl_nxt;
    logic [31:0]   cnt_r, cnt_nxt;
    logic          rpulse_r, rpulse_nxt;
    logic          wp_s1_r, wp_s2_r;
    logic [7:0]    rdata_r, rdata_nxt;
    logic [5:0]    hit;
    logic          alert_any;

    // ==========================================================
    // alert gating
    assign hit[0] = |(i_fault & mask_r[0]);
    genvar g;
    generate
        for (g = 1; g < 6; g++) begin : g_alarm
            assign hit[g] = |(i_alarm[(g-1)*8 +: 8] & mask_r[g]);
        end
    endgenerate

    always_comb begin
        alert_any = (|hit) ||
                    (|({movf_r, alatch_r} & i_cfg3_mask)) ||
                    (i_conv_done && i_gpio_setup_two_mask) ||
                    (ldone_r && lal_r);
    end

    assign o_alert = alert_any;

    // ==========================================================
    // copy map
    function automatic logic [7:0] copy_addr(input logic [3:0] i);
        if (i < mfr_pkg::LOG_ADC0) begin
            copy_addr = mfr_pkg::NVM_FAULT + {4'h0, i};
        end else begin
            copy_addr = mfr_pkg::NVM_ADC +
                        {4'h0, i - mfr_pkg::LOG_ADC0};
        end
    endfunction

    function automatic logic [7:0] copy_data(input logic [3:0] i);
        case (i)
            4'h0:    copy_data = i_fault;
            4'h1:    copy_data = i_alarm[7:0];
            4'h2:    copy_data = i_alarm[15:8];
            4'h3:    copy_data = i_alarm[23:16];
            4'h4:    copy_data = i_alarm[31:24];
            4'h5:    copy_data = i_alarm[39:32];
            4'h6:    copy_data = i_sense_now;
            4'h7:    copy_data = i_sense_min;
            4'h8:    copy_data = i_sense_max;
            4'h9:    copy_data = i_rail_now;
            4'hA:    copy_data = i_rail_min;
            default: copy_data = i_rail_max;
        endcase
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic wm, ws, wl, wr2, clr_ok;
        wm  = i_wr && (i_addr == mfr_pkg::ADDR_METER);
        ws  = i_wr && (i_addr == mfr_pkg::ADDR_SNAP);
        wl  = i_wr && (i_addr == mfr_pkg::ADDR_LOG);
        wr2 = i_wr && (i_addr == mfr_pkg::ADDR_RST);
        clr_ok = wl && (unl_r || i_wdata[mfr_pkg::LOG_UNLOCK]);
        for (int k = 0; k < 6; k++) begin
            mask_nxt[k] = mask_r[k];
        end
        if (i_wr && mask_hit(i_addr)) begin
            mask_nxt[mask_idx(i_addr)] = i_wdata;
        end
        // meter control
        mreset_nxt = wm ? i_wdata[mfr_pkg::MTR_RESET] : mreset_r;
        mhalt_nxt  = wm ? i_wdata[mfr_pkg::MTR_HALT] : mhalt_r;
        tick_nxt = tick_r;
        if (wm && !i_wdata[mfr_pkg::MTR_TICK]) begin
            tick_nxt = 1'b0;
        end
        if (i_tick_wrap) begin
            tick_nxt = 1'b1;
        end
        movf_nxt = movf_r;
        if (wm && !i_wdata[mfr_pkg::MTR_OVF]) begin
            movf_nxt = 1'b0;
        end
        if (i_meter_ovf) begin
            movf_nxt = 1'b1;
        end
        alatch_nxt = alatch_r;
        if (wm && !i_wdata[mfr_pkg::MTR_ALERT]) begin
            alatch_nxt = 1'b0;
        end
        if (alert_any) begin
            alatch_nxt = 1'b1;
        end
        // snapshot
        sel_nxt   = ws ? i_wdata[mfr_pkg::SNAP_LSB +: 4] : sel_r;
        shalt_nxt = ws ? i_wdata[mfr_pkg::SNAP_HALT] : shalt_r;
        // fault capture control
        len_nxt = wl ? i_wdata[mfr_pkg::LOG_EN] : len_r;
        unl_nxt = wl ? i_wdata[mfr_pkg::LOG_UNLOCK] : unl_r;
        lal_nxt = wl ? i_wdata[mfr_pkg::LOG_ALERT] : lal_r;
        lst_nxt = lst_r;
        ldone_nxt = ldone_r;
        if (clr_ok && !i_wdata[mfr_pkg::LOG_START]) begin
            lst_nxt = 1'b0;
        end
        if (clr_ok && !i_wdata[mfr_pkg::LOG_DONE]) begin
            ldone_nxt = 1'b0;
        end
        st_nxt = st_r;
        idx_nxt = idx_r;
        case (st_r)
            ST_IDLE: begin
                if (len_r && i_fault_event && !lst_r && !ldone_r) begin
                    st_nxt  = ST_COPY;
                    idx_nxt = 4'h0;
                    lst_nxt = 1'b1;
                end
            end
            ST_COPY: begin
                if (i_nvm_ready) begin
                    if (idx_r == mfr_pkg::LOG_STEPS - 4'h1) begin
                        st_nxt = ST_FIN;
                    end else begin
                        idx_nxt = idx_r + 4'h1;
                    end
                end
            end
            ST_FIN: begin
                ldone_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        naddr_nxt = copy_addr(idx_nxt);
        ndata_nxt = copy_data(idx_nxt);
        // auto restart
        ren_nxt = wr2 ? i_wdata[mfr_pkg::RST_EN] : ren_r;
        rdl_nxt = wr2 ? i_wdata[mfr_pkg::RST_DL_LSB +: 3] : rdl_r;
        cnt_nxt = cnt_r;
        rpulse_nxt = 1'b0;
        if (cnt_r != 32'h0) begin
            cnt_nxt = cnt_r - 32'h1;
            rpulse_nxt = (cnt_r == 32'h1);
        end
        if (wr2 && i_wdata[mfr_pkg::RST_EN] && !ren_r) begin
            // only a 0 to 1 change arms a restart
            cnt_nxt = P_BASE_CYC << i_wdata[mfr_pkg::RST_DL_LSB +: 3];
        end else if (wr2 && !i_wdata[mfr_pkg::RST_EN]) begin
            cnt_nxt = 32'h0;
        end
        // read data
        rdata_nxt = rdata_r;
        if (i_rd) begin
            if (i_addr == mfr_pkg::ADDR_METER) begin
                rdata_nxt = {mreset_r, mhalt_r, tick_r, movf_r,
                             alatch_r, i_nvm_factory_locked, 2'b00};
            end else if (i_addr == mfr_pkg::ADDR_SNAP) begin
                rdata_nxt = {sel_r, shalt_r, 3'b000};
            end else if (i_addr == mfr_pkg::ADDR_LOG) begin
                rdata_nxt = {len_r, unl_r, lst_r, ldone_r,
                             lal_r, 3'b000};
            end else if (i_addr == mfr_pkg::ADDR_RST) begin
                rdata_nxt = {ren_r, rdl_r, 2'b00,
                             (cnt_r != 32'h0) || i_cool_busy,
                             wp_s2_r};
            end else if (mask_hit(i_addr)) begin
                rdata_nxt = mask_r[mask_idx(i_addr)];
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 6; k++) begin
                mask_r[k] <= mfr_pkg::REG_RESET;
            end
            mreset_r <= 1'b0;
            mhalt_r  <= 1'b0;
            tick_r   <= 1'b0;
            movf_r   <= 1'b0;
            alatch_r <= 1'b0;
            sel_r    <= 4'h0;
            shalt_r  <= 1'b0;
            len_r    <= 1'b0;
            unl_r    <= 1'b0;
            lst_r    <= 1'b0;
            ldone_r  <= 1'b0;
            lal_r    <= 1'b0;
            st_r     <= ST_IDLE;
            idx_r    <= 4'h0;
            naddr_r  <= mfr_pkg::NVM_FAULT;
            ndata_r  <= 8'h00;
            ren_r    <= 1'b0;
            rdl_r    <= 3'h0;
            cnt_r    <= 32'h0;
            rpulse_r <= 1'b0;
            wp_s1_r  <= 1'b0;
            wp_s2_r  <= 1'b0;
            rdata_r  <= 8'h00;
        end else begin
            mask_r   <= mask_nxt;
            mreset_r <= mreset_nxt;
            mhalt_r  <= mhalt_nxt;
            tick_r   <= tick_nxt;
            movf_r   <= movf_nxt;
            alatch_r <= alatch_nxt;
            sel_r    <= sel_nxt;
            shalt_r  <= shalt_nxt;
            len_r    <= len_nxt;
            unl_r    <= unl_nxt;
            lst_r    <= lst_nxt;
            ldone_r  <= ldone_nxt;
            lal_r    <= lal_nxt;
            st_r     <= st_nxt;
            idx_r    <= idx_nxt;
            naddr_r  <= naddr_nxt;
            ndata_r  <= ndata_nxt;
            ren_r    <= ren_nxt;
            rdl_r    <= rdl_nxt;
            cnt_r    <= cnt_nxt;
            rpulse_r <= rpulse_nxt;
            wp_s1_r  <= i_wp_pin;
            wp_s2_r  <= wp_s1_r;
            rdata_r  <= rdata_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign o_rdata       = rdata_r;
    assign o_meter_reset = mreset_r;
    assign o_meter_halt  = mhalt_r;
    assign o_snap_sel    = sel_r;
    assign o_snap_halt   = shalt_r;
    assign o_nvm_we      = (st_r == ST_COPY);
    assign o_nvm_addr    = naddr_r;
    assign o_nvm_data    = ndata_r;
    assign o_restart     = rpulse_r;
endmodule
`default_nettype wire

// File: mfr_pkg.sv
// constants for the meter, fault capture and auto restart registers
// ==========================================================
package mfr_pkg;
    // ==========================================================
    // register offsets, mask count and reset value
    localparam logic [7:0] ADDR_MASK0 = 8'h15;
    localparam logic [7:0] MASK_CNT   = 8'h06;
    localparam logic [7:0] ADDR_METER = 8'h84;
    localparam logic [7:0] ADDR_SNAP  = 8'h85;
    localparam logic [7:0] ADDR_LOG   = 8'h90;
    localparam logic [7:0] ADDR_RST   = 8'hA2;
    localparam logic [7:0] REG_RESET  = 8'h00;
    // ==========================================================
    // field positions
    localparam int MTR_RESET  = 7;
    localparam int MTR_HALT   = 6;
    localparam int MTR_TICK   = 5;
    localparam int MTR_OVF    = 4;
    localparam int MTR_ALERT  = 3;
    localparam int MTR_LOCK   = 2;
    localparam int SNAP_LSB   = 4;
    localparam int SNAP_HALT  = 3;
    localparam int LOG_EN     = 7;
    localparam int LOG_UNLOCK = 6;
    localparam int LOG_START  = 5;
    localparam int LOG_DONE   = 4;
    localparam int LOG_ALERT  = 3;
    localparam int RST_EN     = 7;
    localparam int RST_DL_LSB = 4;
    localparam int RST_STAT   = 1;
    localparam int RST_WP     = 0;
    // ==========================================================
    // fault capture copy map
    localparam logic [3:0] LOG_STEPS = 4'hC;
    localparam logic [3:0] LOG_ADC0  = 4'h6;
    localparam logic [7:0] NVM_FAULT = 8'hA4;
    localparam logic [7:0] NVM_ADC   = 8'hE1;
    // ==========================================================
    // timing
    localparam int CLK_MHZ          = 50;
    localparam int RESTART_BASE_US  = 512000;
    localparam int RESTART_BASE_CYC = RESTART_BASE_US * CLK_MHZ;
endpackage

// File: mfr_monitor.sv
// port checker for the meter, capture and restart register bank
`timescale 1ns/1ps
`default_nettype none
module mfr_monitor #(
    parameter logic [31:0] P_BASE_CYC = 32'd4
) (
    // watched ports
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       o_meter_reset,
    input wire logic       o_meter_halt,
    input wire logic       i_nvm_factory_locked,
    input wire logic [3:0] o_snap_sel,
    input wire logic       o_snap_halt,
    input wire logic       o_alert,
    input wire logic       o_nvm_we,
    input wire logic [7:0] o_nvm_addr,
    input wire logic       i_nvm_ready,
    input wire logic       o_restart
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // properties
    sequence s_acc;
        o_nvm_we && i_nvm_ready;
    endsequence
    property p_snap;
        i_wr && i_addr == 8'h85 |=> o_snap_sel == $past(i_wdata[7:4])
            && o_snap_halt == $past(i_wdata[3]);
    endproperty
    a_snap: assert property (p_snap)
        else $error("snap field");
    property p_meter;
        i_wr && i_addr == 8'h84 |=> o_meter_reset == $past(i_wdata[7])
            && o_meter_halt == $past(i_wdata[6]);
    endproperty
    a_meter: assert property (p_meter) else $error("meter ctl");
    property p_lock;
        i_rd && i_addr == 8'h84 |=> o_rdata[1:0] == 2'h0
            && o_rdata[2] == $past(i_nvm_factory_locked);
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock bits");
    property p_latch;
        o_alert ##1 (i_rd && i_addr == 8'h84) |=> o_rdata[3];
    endproperty
    a_latch: assert property (p_latch)
        else $error("alert latch");
    property p_first;
        $rose(o_nvm_we) |-> o_nvm_addr == 8'hA4;
    endproperty
    a_first: assert property (p_first) else $error("first addr");
    property p_hold;
        o_nvm_we && !i_nvm_ready |=> o_nvm_we && $stable(o_nvm_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("nvm hold");
    property p_step;
        s_acc ##0 o_nvm_addr != 8'hE6 |=> o_nvm_we && o_nvm_addr ==
            ($past(o_nvm_addr) == 8'hA9 ? 8'hE1 : $past(o_nvm_addr) + 8'h01);
    endproperty
    a_step: assert property (p_step)
        else $error("nvm step");
    property p_end;
        s_acc ##0 o_nvm_addr == 8'hE6 |=> !o_nvm_we ##1 !o_nvm_we;
    endproperty
    a_end: assert property (p_end) else $error("nvm end");
    property p_pulse;
        o_restart |=> !o_restart [*4];
    endproperty
    a_pulse: assert property (p_pulse) else $error("restart pulse");
endmodule
bind mfr_regs mfr_monitor #(.P_BASE_CYC(P_BASE_CYC)) u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_meter_reset(o_meter_reset), .o_meter_halt(o_meter_halt),
    .i_nvm_factory_locked(i_nvm_factory_locked), .o_snap_sel(o_snap_sel),
    .o_snap_halt(o_snap_halt), .o_alert(o_alert), .o_nvm_we(o_nvm_we),
    .o_nvm_addr(o_nvm_addr), .i_nvm_ready(i_nvm_ready),
    .o_restart(o_restart)
);
`default_nettype wire

// File: mfr_nvm_model.sv
// nonvolatile memory model taking capture bytes
`timescale 1ns/1ps
`default_nettype none
module mfr_nvm_model (
    // write side
    input  wire logic       i_clk,
    input  wire logic       i_we,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_data,
    input  wire logic       i_slow,
    output logic            o_ready
);
    logic [7:0] mem [256];
    int         n_wr = 0;
    logic       ph_r = 1'b0;
    // slow mode accepts every other cycle
    assign o_ready = !i_slow || ph_r;
    always @(posedge i_clk) begin
        ph_r <= !ph_r;
        if (i_we && o_ready) begin
            mem[i_addr] <= i_data;
            n_wr <= n_wr + 1;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    err_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic        i_clk, i_rst_n, i_wr, i_rd, i_tick, i_ovf, i_lock, i_conv;
    logic        i_evt, i_wp, i_cool, i_gmask, rdy, we, alert, rst_p, slow;
    logic        m_rst, m_halt, s_halt;
    logic [1:0]  i_cfg3;
    logic [3:0]  s_sel;
    logic [7:0]  i_addr, i_wdata, i_fault, rdata, n_addr, n_data;
    logic [39:0] i_alarm;
    logic [47:0] adc_v;
    logic [95:0] exp_b;
    int          err_count = 0;
    int          n_checks = 0;
    int          n;
    mfr_regs #(.P_BASE_CYC(32'd4)) uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(rdata),
        .i_tick_wrap(i_tick), .i_meter_ovf(i_ovf), .o_meter_reset(m_rst),
        .o_meter_halt(m_halt), .i_nvm_factory_locked(i_lock),
        .o_snap_sel(s_sel), .o_snap_halt(s_halt), .i_conv_done(i_conv),
        .i_fault(i_fault), .i_alarm(i_alarm), .i_cfg3_mask(i_cfg3),
        .i_gpio_setup_two_mask(i_gmask), .o_alert(alert),
        .i_fault_event(i_evt), .i_sense_now(adc_v[7:0]),
        .i_sense_min(adc_v[15:8]), .i_sense_max(adc_v[23:16]),
        .i_rail_now(adc_v[31:24]), .i_rail_min(adc_v[39:32]),
        .i_rail_max(adc_v[47:40]), .o_nvm_we(we), .o_nvm_addr(n_addr),
        .o_nvm_data(n_data), .i_nvm_ready(rdy), .i_wp_pin(i_wp),
        .i_cool_busy(i_cool), .o_restart(rst_p)
    );
    mfr_nvm_model u_nvm (
        .i_clk(i_clk), .i_we(we), .i_addr(n_addr), .i_data(n_data),
        .i_slow(slow), .o_ready(rdy)
    );
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // ==========================================================
    // bus and helper tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK("rdata", ex, rdata)
    endtask
    task automatic fire();
        @(posedge i_clk);
        i_evt <= 1'b1;
        @(posedge i_clk);
        i_evt <= 1'b0;
        #1;
        for (int k = 0; k < 40 && we; k++) @(posedge i_clk) #1;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic wait_rst(output int c);
        c = 0;
        #1;
        while (!rst_p && c < 80) begin
            @(posedge i_clk) #1;
            c++;
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        rd(8'h84, 8'h00);
        rd(8'h90, 8'h00);
        rd(8'hA2, 8'h00);
        wr(8'h33, 8'hFF);
        rd(8'h33, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr(8'h85, {c[3:0], c[0], 3'h7});
            rd(8'h85, {c[3:0], c[0], 3'h0});
            `CHK("sel", c[3:0], s_sel)
            `CHK("halt", c[0], s_halt)
        end
        @(posedge i_clk);
        i_lock <= 1'b1;
        wr(8'h84, 8'hFF);
        rd(8'h84, 8'hC4);
        `CHK("meter", 2'b11, {m_rst, m_halt})
        @(posedge i_clk);
        i_lock <= 1'b0;
        wr(8'h84, 8'h00);
        @(posedge i_clk);
        i_tick <= 1'b1;
        @(posedge i_clk);
        i_tick <= 1'b0;
        rd(8'h84, 8'h20);
        @(posedge i_clk);
        i_ovf <= 1'b1;
        @(posedge i_clk);
        i_ovf <= 1'b0;
        rd(8'h84, 8'h30);
        wr(8'h84, 8'h00);
        rd(8'h84, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_alert();
        wr(8'h15, 8'h04);
        wr(8'h1A, 8'h80);
        i_fault <= 8'hFB;
        #1;
        `CHK("alert", 1'b0, alert)
        @(posedge i_clk);
        i_fault <= 8'h04;
        #1;
        `CHK("alert", 1'b1, alert)
        @(posedge i_clk);
        i_fault <= 8'h00;
        i_alarm <= 40'h80_0000_0000;
        #1;
        `CHK("alert", 1'b1, alert)
        @(posedge i_clk);
        i_alarm <= 40'h0;
        i_conv <= 1'b1;
        #1;
        `CHK("alert", 1'b0, alert)
        @(posedge i_clk);
        i_gmask <= 1'b1;
        #1;
        `CHK("alert", 1'b1, alert)
        @(posedge i_clk);
        i_conv <= 1'b0;
        rd(8'h84, 8'h08);
        wr(8'h84, 8'h00);
        rd(8'h84, 8'h00);
        @(posedge i_clk);
        i_cfg3 <= 2'b01;
        i_ovf <= 1'b1;
        @(posedge i_clk);
        i_ovf <= 1'b0;
        #1;
        `CHK("alert", 1'b0, alert)
        @(posedge i_clk);
        i_cfg3 <= 2'b10;
        #1;
        `CHK("alert", 1'b1, alert)
        rd(8'h84, 8'h18);
        @(posedge i_clk);
        i_cfg3 <= 2'b00;
        wr(8'h84, 8'h00);
        rd(8'h84, 8'h00);
        $display("test alert done");
    endtask
    task automatic t_log();
        wr(8'h90, 8'h88);
        i_fault <= 8'h5A;
        i_alarm <= 40'h01_2345_6789;
        adc_v <= 48'hC6C5_C4C3_C2C1;
        slow <= 1'b1;
        fire();
        exp_b = {adc_v, i_alarm, i_fault};
        for (int k = 0; k < 12; k++) begin
            n = (k < 6) ? 32'hA4 + k : 32'hDB + k;
            `CHK("nvm", exp_b[8*k +: 8], u_nvm.mem[n])
        end
        rd(8'h90, 8'hB8);
        `CHK("alert", 1'b1, alert)
        fire();
        `CHK("count", 12, u_nvm.n_wr)
        wr(8'h90, 8'h88);
        rd(8'h90, 8'hB8);
        wr(8'h90, 8'hC8);
        rd(8'h90, 8'hC8);
        @(posedge i_clk);
        slow <= 1'b0;
        wr(8'h90, 8'h88);
        fire();
        `CHK("count", 24, u_nvm.n_wr)
        wr(8'h90, 8'h78);
        rd(8'h90, 8'h78);
        wr(8'h90, 8'h48);
        rd(8'h90, 8'h48);
        fire();
        `CHK("count", 24, u_nvm.n_wr)
        $display("test capture done");
    endtask
    task automatic t_restart();
        i_wp <= 1'b1;
        i_cool <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(8'hA2, 8'h03);
        @(posedge i_clk);
        i_wp <= 1'b0;
        i_cool <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            wr(8'hA2, 8'h00);
            wr(8'hA2, {1'b1, c[2:0], 4'h0});
            wait_rst(n);
            `CHK("delay", (4 << c), n)
        end
        wr(8'hA2, 8'h00);
        wr(8'hA2, 8'hB0);
        rd(8'hA2, 8'hB2);
        wait_rst(n);
        rd(8'hA2, 8'hB0);
        wr(8'hA2, 8'hB0);
        wait_rst(n);
        `CHK("rearm", 80, n)
        $display("test restart done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {i_rst_n, i_wr, i_rd, i_tick, i_ovf, i_lock, i_conv} = '0;
        {i_evt, i_wp, i_cool, i_gmask, slow, i_cfg3} = '0;
        {i_addr, i_wdata, i_fault, i_alarm, adc_v} = '0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_alert();
        t_log();
        t_restart();
        final_report();
    end
    initial begin
        #200000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
